/* rtl/cfg_protect_pkg.sv */
// constants for the configuration partition and protection block
package cfg_protect_pkg;
  // word indices of the configuration words; byte address is four times
  localparam logic [17:0] IDX_PART_WP = 18'h0800A;
  localparam logic [17:0] IDX_CODE_PROT = 18'h0800B;
  localparam logic [17:0] IDX_CTRL = 18'h08010;
  localparam logic [17:0] IDX_STATUS = 18'h08011;
  localparam logic [17:0] ADDR_PART_WP = IDX_PART_WP << 2;
  localparam logic [17:0] ADDR_CODE_PROT = IDX_CODE_PROT << 2;
  localparam logic [17:0] ADDR_CTRL = IDX_CTRL << 2;
  localparam logic [17:0] ADDR_STATUS = IDX_STATUS << 2;

  // partition and write-protect word fields
  localparam int BIT_LVP = 13;
  localparam int BIT_SAF_WL = 11;
  localparam int BIT_EE_WL = 10;
  localparam int BIT_CFG_WL = 9;
  localparam int BIT_BOOT_WL = 8;
  localparam int BIT_APP_WL = 7;
  localparam int BIT_SAF_EN = 4;
  localparam int BIT_BOOT_EN = 3;
  localparam int BIT_SIZE_HI = 2;
  localparam int BIT_SIZE_LO = 0;
  localparam logic [15:0] PART_WP_IMPL = 16'h2F9F;
  localparam logic [15:0] PART_WP_LOCKS = 16'h0F80;

  // code protection word fields
  localparam int BIT_EE_RP = 1;
  localparam int BIT_FLASH_RP = 0;
  localparam logic [15:0] CODE_PROT_IMPL = 16'h0003;

  // erased state of a configuration word
  localparam logic [15:0] CFG_ERASED = 16'hFFFF;

  // control and status fields
  localparam int BIT_CTRL_ERASE = 0;
  localparam int BIT_CTRL_LVP_SESSION = 1;
  localparam int BIT_ST_WERR = 0;
  localparam int BIT_ST_BOOT_EN = 1;
  localparam int BIT_ST_SAF_EN = 2;
  localparam int BIT_ST_FLASH_RP = 3;
  localparam int BIT_ST_EE_RP = 4;

  localparam int PROG_WORDS = 16384;
  localparam int SAF_WORDS = 128;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REG_APP,
    REG_BOOT,
    REG_SAF
  } flash_region_e;
endpackage

/* rtl/config_memory_partition_protect.sv */
// configuration word decode, partition map and write/read protection
`timescale 1ns/1ps
`default_nettype none
module config_memory_partition_protect
  import cfg_protect_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int PROG_AW = 14
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic master_clear_cfg_enable,
  input wire logic nvm_wr_req,
  input wire logic nvm_wr_eeprom,
  input wire logic nvm_wr_config,
  input wire logic [PROG_AW-1:0] nvm_wr_addr,
  input wire logic fetch_valid,
  input wire logic [PROG_AW-1:0] fetch_addr,
  output logic nvm_wr_grant,
  output logic nvm_wr_deny,
  output logic exec_fault,
  output logic low_voltage_prog_enable,
  output logic master_clear_pin_enable,
  output logic boot_enable,
  output logic [PROG_AW-1:0] boot_end,
  output logic storage_area_enable,
  output logic flash_read_protect,
  output logic eeprom_read_protect
);

  localparam logic [PROG_AW-1:0] HALF_END = PROG_AW'(PROG_WORDS / 2 - 1);
  localparam logic [PROG_AW-1:0] SAF_BASE =
    PROG_AW'(PROG_WORDS - SAF_WORDS);

  function automatic logic [15:0] merge16(input logic [15:0] cur,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    logic [15:0] r;
    r = cur;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // axi write channel

  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic do_write, wr_hit;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    do_write = aw_held_q && w_held_q && !bvalid_q;
    wr_hit = (awaddr_q == ADDR_W'(ADDR_PART_WP)) ||
             (awaddr_q == ADDR_W'(ADDR_CODE_PROT)) ||
             (awaddr_q == ADDR_W'(ADDR_CTRL)) ||
             (awaddr_q == ADDR_W'(ADDR_STATUS));
    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_held_d && !bvalid_d && !do_write;
    wready_d = !w_held_d && !bvalid_d && !do_write;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration words, control and status

  logic [15:0] part_q, part_d, prot_q, prot_d;
  logic lvp_session_q, lvp_session_d, werr_q, werr_d;
  logic erase_now, cfg_reject, part_sel, prot_sel;
  logic [15:0] part_m, prot_m;
  logic [2:0] size_code;
  logic [PROG_AW-1:0] end_raw, end_d;
  logic grant_q, grant_d, deny_q, deny_d, fault_q, fault_d;
  logic nvm_ok;
  flash_region_e region;

  always_comb begin
    part_d = part_q;
    prot_d = prot_q;
    lvp_session_d = lvp_session_q;
    part_sel = do_write && awaddr_q == ADDR_W'(ADDR_PART_WP);
    prot_sel = do_write && awaddr_q == ADDR_W'(ADDR_CODE_PROT);
    erase_now = do_write && awaddr_q == ADDR_W'(ADDR_CTRL) &&
                wstrb_q[0] && wdata_q[BIT_CTRL_ERASE];
    cfg_reject = (part_sel || prot_sel) && !part_q[BIT_CFG_WL];
    part_m = merge16(part_q, wdata_q, wstrb_q) | ~PART_WP_IMPL;
    prot_m = merge16(prot_q, wdata_q, wstrb_q) | ~CODE_PROT_IMPL;
    if (part_sel && !cfg_reject) begin
      part_d = part_m;
      part_d = part_d & (~PART_WP_LOCKS | part_q);
      if (lvp_session_q && part_q[BIT_LVP]) begin
        part_d[BIT_LVP] = 1'b1;
      end
      if (!part_q[BIT_BOOT_EN]) begin
        part_d[BIT_SIZE_HI:BIT_SIZE_LO] = part_q[BIT_SIZE_HI:BIT_SIZE_LO];
      end
    end
    if (prot_sel && !cfg_reject) begin
      prot_d = prot_q & prot_m;
    end
    if (do_write && awaddr_q == ADDR_W'(ADDR_CTRL) && wstrb_q[0]) begin
      lvp_session_d = wdata_q[BIT_CTRL_LVP_SESSION];
    end
    if (erase_now) begin
      part_d = CFG_ERASED;
      prot_d = CFG_ERASED;
    end
  end

  always_comb begin
    size_code = part_d[BIT_SIZE_HI:BIT_SIZE_LO];
    case (size_code)
      3'h7: end_raw = PROG_AW'(16'h01FF);
      3'h6: end_raw = PROG_AW'(16'h03FF);
      3'h5: end_raw = PROG_AW'(16'h07FF);
      3'h4: end_raw = PROG_AW'(16'h0FFF);
      3'h3: end_raw = PROG_AW'(16'h1FFF);
      default: end_raw = PROG_AW'(16'h3FFF);
    endcase
    end_d = (end_raw > HALF_END) ? HALF_END : end_raw;
  end

  // write check against the map as it stands this cycle
  always_comb begin
    // storage area at top of flash
    if (!part_q[BIT_SAF_EN] && nvm_wr_addr >= SAF_BASE) begin
      region = REG_SAF;
    end else if (!part_q[BIT_BOOT_EN] && nvm_wr_addr <= boot_end) begin
      region = REG_BOOT;
    end else begin
      region = REG_APP;
    end
    case (region)
      REG_SAF: nvm_ok = part_q[BIT_SAF_WL];
      REG_BOOT: nvm_ok = part_q[BIT_BOOT_WL];
      REG_APP: nvm_ok = part_q[BIT_APP_WL];
      default: nvm_ok = 1'b0;
    endcase
    if (nvm_wr_eeprom) begin
      nvm_ok = part_q[BIT_EE_WL];
    end else if (nvm_wr_config) begin
      nvm_ok = part_q[BIT_CFG_WL];
    end
    grant_d = nvm_wr_req && nvm_ok;
    deny_d = nvm_wr_req && !nvm_ok;
    fault_d = fetch_valid && !part_q[BIT_SAF_EN] && fetch_addr >= SAF_BASE;
    // sticky write error, set beats clear
    werr_d = werr_q;
    if (do_write && awaddr_q == ADDR_W'(ADDR_STATUS) && wstrb_q[0] &&
        wdata_q[BIT_ST_WERR]) begin
      werr_d = 1'b0;
    end
    if (deny_d || cfg_reject) begin
      werr_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      part_q <= CFG_ERASED;
      prot_q <= CFG_ERASED;
      lvp_session_q <= 1'b0;
      werr_q <= 1'b0;
      grant_q <= 1'b0;
      deny_q <= 1'b0;
      fault_q <= 1'b0;
      boot_end <= HALF_END;
      low_voltage_prog_enable <= 1'b1;
      master_clear_pin_enable <= 1'b1;
      boot_enable <= 1'b0;
      storage_area_enable <= 1'b0;
      flash_read_protect <= 1'b0;
      eeprom_read_protect <= 1'b0;
    end else begin
      part_q <= part_d;
      prot_q <= prot_d;
      lvp_session_q <= lvp_session_d;
      werr_q <= werr_d;
      grant_q <= grant_d;
      deny_q <= deny_d;
      fault_q <= fault_d;
      boot_end <= part_d[BIT_BOOT_EN] ? '0 : end_d;
      low_voltage_prog_enable <= part_d[BIT_LVP];
      master_clear_pin_enable <= part_d[BIT_LVP] || master_clear_cfg_enable;
      boot_enable <= !part_d[BIT_BOOT_EN];
      storage_area_enable <= !part_d[BIT_SAF_EN];
      // protection follows the new word at once
      flash_read_protect <= !prot_d[BIT_FLASH_RP];
      eeprom_read_protect <= !prot_d[BIT_EE_RP];
    end
  end

  assign nvm_wr_grant = grant_q;
  assign nvm_wr_deny = deny_q;
  assign exec_fault = fault_q;

  //////////////////////////////////////////////////////////////////////////
  // axi read channel

  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      case (s_axi_araddr)
        ADDR_W'(ADDR_PART_WP): rdata_d[15:0] = part_q;
        ADDR_W'(ADDR_CODE_PROT): rdata_d[15:0] = prot_q;
        ADDR_W'(ADDR_CTRL): rdata_d[BIT_CTRL_LVP_SESSION] = lvp_session_q;
        ADDR_W'(ADDR_STATUS): begin
          rdata_d[BIT_ST_WERR] = werr_q;
          rdata_d[BIT_ST_BOOT_EN] = boot_enable;
          rdata_d[BIT_ST_SAF_EN] = storage_area_enable;
          rdata_d[BIT_ST_FLASH_RP] = flash_read_protect;
          rdata_d[BIT_ST_EE_RP] = eeprom_read_protect;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
    // reopen the address channel once reset has let go
    if (!arready_q && !rvalid_q) begin
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  //////////////////////////////////////////////////////////////////////////
  // checks

  chk_lvp_forces_master_clear_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    low_voltage_prog_enable |-> master_clear_pin_enable)
    else $error("lvp set but master clear pin not forced");

  chk_lvp_session_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    lvp_session_q && part_q[BIT_LVP] |=> part_q[BIT_LVP])
    else $error("lvp bit cleared during lvp session");

  chk_lock_no_relax: assert property (@(posedge aclk) disable iff (!aresetn)
    (!part_q[BIT_BOOT_WL] && !erase_now) |=> !part_q[BIT_BOOT_WL])
    else $error("boot write lock relaxed without bulk erase");

  chk_size_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    (!part_q[BIT_BOOT_EN] && !erase_now) |=> $stable(part_q[2:0]))
    else $error("boot size changed while boot enabled");

  chk_cp_no_relax: assert property (@(posedge aclk) disable iff (!aresetn)
    (!prot_q[BIT_FLASH_RP] && !erase_now) |=> !prot_q[BIT_FLASH_RP])
    else $error("flash read protect relaxed without bulk erase");

  chk_eeprom_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_wr_req && nvm_wr_eeprom && !part_q[BIT_EE_WL]
      |=> nvm_wr_deny && !nvm_wr_grant)
    else $error("eeprom write not denied under lock");

  chk_deny_sets_err: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_wr_deny |-> werr_q)
    else $error("denied write did not raise write error");

  chk_cfg_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!part_q[BIT_CFG_WL] && !erase_now) |=> $stable(prot_q))
    else $error("code protection word written under config lock");

  chk_saf_exec: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_valid && storage_area_enable && fetch_addr >= SAF_BASE
      && !erase_now |=> exec_fault)
    else $error("fetch from storage area not flagged");

  chk_boot_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
    boot_enable |-> boot_end <= HALF_END && boot_end[8:0] == 9'h1FF)
    else $error("boot end outside the half-flash limit");

  chk_erase_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    erase_now |=> part_q == CFG_ERASED && !flash_read_protect)
    else $error("bulk erase left protection in place");

endmodule
`default_nettype wire

/* verif/config_memory_partition_protect_bench.sv */
// self-checking bench for the configuration protection block
`timescale 1ns/1ps
`default_nettype none
module config_memory_partition_protect_bench;
  import cfg_protect_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h00000;
  logic [17:0] s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic mce = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, nvm_wr_req, nvm_wr_eeprom, nvm_wr_config;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, q, rr;
  logic [13:0] nvm_wr_addr, fetch_addr, boot_end;
  logic fetch_valid, nvm_wr_grant, nvm_wr_deny, exec_fault, f, sess;
  logic low_voltage_prog_enable, master_clear_pin_enable, boot_enable;
  logic storage_area_enable, flash_read_protect, eeprom_read_protect;
  logic [15:0] cw, cp;
  logic [19:0] obs;
  int lk[5] = '{7, 8, 11, 10, 9};
  int n_fail = 0;
  int tests_run = 0;
  int seed = 35;

  always #10 aclk = ~aclk;
  assign obs = {boot_enable, boot_end, storage_area_enable,
    low_voltage_prog_enable, master_clear_pin_enable, flash_read_protect,
    eeprom_read_protect};

  config_memory_partition_protect i_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_clear_cfg_enable(mce), .nvm_wr_req, .nvm_wr_eeprom,
    .nvm_wr_config, .nvm_wr_addr, .fetch_valid, .fetch_addr, .nvm_wr_grant,
    .nvm_wr_deny, .exec_fault, .low_voltage_prog_enable,
    .master_clear_pin_enable, .boot_enable, .boot_end, .storage_area_enable,
    .flash_read_protect, .eeprom_read_protect);

  nvm_master_model i_nvm (.aclk, .nvm_wr_req, .nvm_wr_eeprom, .nvm_wr_config,
    .nvm_wr_addr, .fetch_valid, .fetch_addr, .nvm_wr_grant, .nvm_wr_deny,
    .exec_fault);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [13:0] bend(input logic [15:0] w);
    if (w[3]) return 14'h0000;
    case (w[2:0])
      3'h7: return 14'h01FF;
      3'h6: return 14'h03FF;
      3'h5: return 14'h07FF;
      3'h4: return 14'h0FFF;
      default: return 14'h1FFF;
    endcase
  endfunction

  // locks only fall; size frozen once boot enabled; config lock freezes all
  function automatic logic [15:0] nxt(input logic [15:0] o,
                                      input logic [15:0] d, input logic s);
    logic [15:0] n;
    n = (d | ~PART_WP_IMPL) & ~PART_WP_LOCKS | (o & d & PART_WP_LOCKS);
    if (s && !d[13]) n[13] = o[13];
    if (!o[3]) n[2:0] = o[2:0];
    return o[9] ? n : o;
  endfunction

  function automatic logic ok(input logic [1:0] k, input logic [13:0] a,
                              input logic [15:0] w);
    if (k[0]) return w[10];
    if (k[1]) return w[9];
    if (!w[4] && a >= 14'h3F80) return w[11];
    if (!w[3] && a <= bend(w)) return w[8];
    return w[7];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic conclude();
    $display("counts tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ready is sampled at the falling edge, acted on at the next rising one
  task automatic wr(input logic [17:0] a, input logic [15:0] d,
                    output logic [1:0] b);
    logic ta, tw, tb;
    int n;
    tb = 1'b0;
    n = 0;
    rr = $random(seed);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {rr[31:16], d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      b = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    chk("write answer", 1, tb);
  endtask

  task automatic rd(input logic [17:0] a, output logic [31:0] d,
                    output logic [1:0] b);
    logic ta, tb;
    int n;
    tb = 1'b0;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tb = s_axi_rvalid;
      d = s_axi_rdata;
      b = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    chk("read answer", 1, tb);
  endtask

  task automatic outs(input string t);
    logic [19:0] ex;
    #1;
    ex = {~cw[3], bend(cw), ~cw[4], cw[13], cw[13] | mce, ~cp[0], ~cp[1]};
    chk(t, ex, obs);
  endtask

  task automatic wcw(input logic wh, input logic [15:0] d);
    logic [17:0] a;
    a = wh ? ADDR_CODE_PROT : ADDR_PART_WP;
    if (!wh) cw = nxt(cw, d, sess);
    else if (cw[9]) cp = cp & (d | ~CODE_PROT_IMPL);
    wr(a, d, r);
    chk("config resp", RESP_OKAY, r);
    rd(a, q, r);
    chk("config rresp", RESP_OKAY, r);
    chk("config word", wh ? cp : cw, q);
    outs("config outs");
  endtask

  task automatic ctl(input logic s, input logic e);
    wr(ADDR_CTRL, {14'h0000, s, e}, r);
    rd(ADDR_CTRL, q, r);
    chk("session", {s, 1'b0}, q);
    sess = s;
    if (e) begin
      cw = CFG_ERASED;
      cp = CFG_ERASED;
    end
  endtask

  task automatic st(input logic e);
    rd(ADDR_STATUS, q, r);
    chk("status", {~cp[1], ~cp[0], ~cw[4], ~cw[3], e}, q);
  endtask

  task automatic nv(input logic [1:0] k, input logic [13:0] a);
    logic [1:0] gd;
    logic e;
    e = ok(k, a, cw);
    i_nvm.try_wr($random(seed) & 3, k, a, gd);
    chk("grant deny", {e, ~e}, gd);
  endtask

  task automatic fe(input logic [13:0] a);
    i_nvm.fetch(a, f);
    chk("exec fault", !cw[4] && a >= 14'h3F80, f);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cw = CFG_ERASED;
    cp = CFG_ERASED;
    sess = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    outs("reset outs");
    rd(ADDR_PART_WP, q, r);
    chk("reset word", 32'h0000FFFF, q);
    rd(18'h00100, q, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped rdata", 32'h00000000, q);
    wr(18'h00100, 16'h0000, r);
    chk("unmapped bresp", RESP_SLVERR, r);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      ctl(1'b0, 1'b1);
      wcw(1'b0, 16'hFFF8 | c[2:0]);
      wcw(1'b0, 16'hFFF0 | c[2:0]);
      wcw(1'b0, 16'hFEF0 | (c[2:0] ^ 3'h5));
      nv(2'b00, bend(cw));
      nv(2'b00, bend(cw) + 14'h0001);
    end
    $display("test boot size done");
    ctl(1'b0, 1'b1);
    wcw(1'b0, 16'hF6FF);
    nv(2'b00, 14'h3FC0);
    nv(2'b00, 14'h0100);
    fe(14'h3FFF);
    ctl(1'b0, 1'b1);
    wcw(1'b0, 16'hFFE7);
    fe(14'h3F7F);
    fe(14'h3F80);
    foreach (lk[i]) begin
      wcw(1'b0, 16'hFFE7 & ~(16'h0001 << lk[i]));
      nv(2'b00, 14'h2000);
      nv(2'b00, 14'h0100);
      nv(2'b00, 14'h3FC0);
      nv(2'b01, 14'h0005);
      nv(2'b10, 14'h0000);
    end
    st(1'b1);
    wr(ADDR_STATUS, 16'h0001, r);
    st(1'b0);
    wcw(1'b0, 16'hFFFF);
    wcw(1'b1, 16'hFFFC);
    st(1'b1);
    $display("test write locks done");
    ctl(1'b0, 1'b1);
    wcw(1'b0, 16'hDFFF);
    @(posedge aclk);
    mce <= 1'b1;
    repeat (2) @(posedge aclk);
    outs("master clear");
    ctl(1'b1, 1'b1);
    wcw(1'b0, 16'hDFFF);
    @(posedge aclk);
    mce <= 1'b0;
    repeat (2) @(posedge aclk);
    outs("session hold");
    ctl(1'b0, 1'b0);
    $display("test programming mode done");
    ctl(1'b0, 1'b1);
    wcw(1'b1, 16'hFFFE);
    wcw(1'b1, 16'hFFFF);
    wcw(1'b1, 16'hFFFD);
    ctl(1'b0, 1'b1);
    outs("erase outs");
    $display("test read protect done");
    repeat (4) begin
      ctl(1'b0, 1'b1);
      rr = $random(seed);
      wcw(1'b1, rr[31:16]);
      wcw(1'b0, rr[15:0]);
      repeat (12) begin
        rr = $random(seed);
        nv(rr[15:14], rr[13:0]);
        fe(rr[29:16]);
      end
    end
    $display("test random done");
    // reset in mid-run must drop every word back to erased
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    cw = CFG_ERASED;
    cp = CFG_ERASED;
    sess = 1'b0;
    repeat (3) @(posedge aclk);
    outs("mid reset outs");
    st(1'b0);
    $display("test mid reset done");
    conclude();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    $display("mismatch watchdog expected finish seen timeout");
    conclude();
  end
endmodule
`default_nettype wire

/* verif/nvm_master_model.sv */
// model of the memory write controller that asks for checked writes
`timescale 1ns/1ps
`default_nettype none
module nvm_master_model (
  input wire logic aclk,
  output logic nvm_wr_req,
  output logic nvm_wr_eeprom,
  output logic nvm_wr_config,
  output logic [13:0] nvm_wr_addr,
  output logic fetch_valid,
  output logic [13:0] fetch_addr,
  input wire logic nvm_wr_grant,
  input wire logic nvm_wr_deny,
  input wire logic exec_fault
);
  initial begin
    nvm_wr_req = 1'b0;
    nvm_wr_eeprom = 1'b0;
    nvm_wr_config = 1'b0;
    nvm_wr_addr = 14'h0000;
    fetch_valid = 1'b0;
    fetch_addr = 14'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // gap idle cycles first, so the far side is seen both prompt and slow;
  // once idle the qualifiers show the inverse so stale values never match
  task automatic try_wr(input int gap, input logic [1:0] k,
                        input logic [13:0] a, output logic [1:0] gd);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    nvm_wr_req <= 1'b1;
    nvm_wr_eeprom <= k[0];
    nvm_wr_config <= k[1];
    nvm_wr_addr <= a;
    @(posedge aclk);
    nvm_wr_req <= 1'b0;
    nvm_wr_eeprom <= ~k[0];
    nvm_wr_config <= ~k[1];
    nvm_wr_addr <= ~a;
    #1 gd = {nvm_wr_grant, nvm_wr_deny};
  endtask

  task automatic fetch(input logic [13:0] a, output logic f);
    @(posedge aclk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge aclk);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a;
    #1 f = exec_fault;
  endtask
endmodule
`default_nettype wire
